// ### ipm_consts.svh
// Purpose: constants for the idle/stop power-mode controller
// Assumes: 8-bit special-function register port from the core
// Notes: offsets, field positions and reset values live here
`ifndef IPM_CONSTS_SVH
`define IPM_CONSTS_SVH
`define IPM_PWR_CTRL_ADDR 8'h87
`define IPM_PWR_CTRL_RST 8'h00
`define IPM_IDLE_BIT 0
`define IPM_STOP_BIT 1
`define IPM_FLAGS_LSB 2
`define IPM_FLAGS_MSB 7
`define IPM_RESET_VECTOR 16'h0000
`endif

// ### ipm_core_model.sv
// Purpose: core model on the register port
// Assumes: changes at the falling edge
// Notes: released data is inverted
`timescale 1ns/1ps
module ipm_core_model (
  input wire logic i_clk, // Clock
  input wire logic [7:0] i_rdata, // Read data
  output logic [7:0] o_addr, // Address
  output logic [7:0] o_wdata, // Write data
  output logic o_wr, // Write strobe
  output logic o_rd, // Read strobe
  output logic o_done // Retire
);
  initial {o_addr, o_wdata, o_wr, o_rd, o_done} = '0;
  task automatic wr_reg(input logic [7:0] d, input logic [7:0] a = 8'h87);
    @(negedge i_clk);
    {o_addr, o_wdata, o_wr} = {a, d, 1'b1};
    @(negedge i_clk);
    {o_wdata, o_wr, o_done} = {~d, 2'b01};
    @(negedge i_clk);
    o_done = 1'b0;
  endtask
  task automatic rd_reg(output logic [7:0] q, input logic [7:0] a = 8'h87);
    @(negedge i_clk);
    {o_addr, o_rd} = {a, 1'b1};
    @(negedge i_clk);
    o_rd = 1'b0;
    @(negedge i_clk);
    q = i_rdata;
  endtask
endmodule // ipm_core_model

// ### ipm_pkg.sv
// Purpose: types for the power-mode controller
// Assumes: nothing
// Notes: one-hot mode states
package ipm_pkg;
  typedef enum logic [2:0] {
    IPM_RUN = 3'h1,
    IPM_IDLE = 3'h2,
    IPM_STOP = 3'h4
  } ipm_mode_t;
endpackage

// ### ipm_power_ctrl.sv
// Purpose: idle/stop power-mode controller with its control register
// Assumes: core writes/reads the register on the special-function port
// Notes: wake-by-reset requests go out as O_SYS_RESET_REQ to the reset block
`include "ipm_consts.svh"
`timescale 1ns/1ps
module ipm_power_ctrl (
  input wire logic I_REF_CLK, // System clock
  input wire logic I_RESET_N, // Async reset, active low
  input wire logic [7:0] I_SFR_ADDR, // Register address
  input wire logic [7:0] I_SFR_WDATA, // Write data
  input wire logic I_SFR_WR, // Write strobe, one cycle
  input wire logic I_SFR_RD, // Read strobe
  input wire logic I_INSTR_DONE, // Core finished current instruction
  input wire logic I_IRQ_PENDING, // Enabled interrupt asserted, core domain
  input wire logic I_WDT_EXPIRED, // Watchdog expiry pulse
  input wire logic I_MCD_ENABLE, // Missing clock detector enabled
  input wire logic I_MCD_TIMEOUT, // Detector timeout, async level
  input wire logic I_PIN_RESET, // External reset pin asserted, async level
  input wire logic I_REG_OFF_IN_STOP, // Regulator stop-shutdown setting
  output logic [7:0] O_SFR_RDATA, // Read data
  output logic O_CORE_CLK_EN, // Processor clock enable
  output logic O_PERIPH_CLK_EN, // Timers/interrupt/serial clock enable
  output logic O_OSC_EN, // Internal oscillator enable
  output logic O_REGULATOR_EN, // Internal regulator enable
  output logic O_IRQ_WAKE, // Pulse: core resumes to service interrupt
  output logic O_SYS_RESET_REQ, // Pulse: request normal reset sequence
  output logic [15:0] O_RESET_VECTOR, // Start address after reset
  output logic O_IDLE, // Idle mode active
  output logic O_STOP // Stop mode active
);
  ipm_pkg::ipm_mode_t mode_ff;
  ipm_pkg::ipm_mode_t nxt_mode;
  logic [5:0] flags_ff;
  logic [5:0] nxt_flags;
  logic idle_req_ff;
  logic nxt_idle_req;
  logic stop_req_ff;
  logic nxt_stop_req;
  logic reg_off_ff;
  logic nxt_reg_off;
  logic wake_ff;
  logic nxt_wake;
  logic rst_req_ff;
  logic nxt_rst_req;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic mcd_sync;
  logic pin_sync;
  logic wr_hit;

  // Timeout and pin come from outside the clock domain
  ipm_sync2 u_sync_mcd (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RESET_N),
    .i_d(I_MCD_TIMEOUT),
    .o_q(mcd_sync)
  );
  ipm_sync2 u_sync_pin (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RESET_N),
    .i_d(I_PIN_RESET),
    .o_q(pin_sync)
  );

  assign wr_hit = I_SFR_WR && (I_SFR_ADDR == `IPM_PWR_CTRL_ADDR);

  always_comb begin
    nxt_flags = flags_ff;
    nxt_idle_req = idle_req_ff;
    nxt_stop_req = stop_req_ff;
    nxt_mode = mode_ff;
    nxt_reg_off = reg_off_ff;
    nxt_wake = 1'b0;
    nxt_rst_req = 1'b0;
    nxt_rdata = rdata_ff;
    if (wr_hit) begin
      nxt_flags = I_SFR_WDATA[`IPM_FLAGS_MSB:`IPM_FLAGS_LSB];
      // Stop takes precedence: it is the deeper state
      if (I_SFR_WDATA[`IPM_STOP_BIT]) begin
        nxt_stop_req = 1'b1;
        nxt_idle_req = 1'b0;
      end else if (I_SFR_WDATA[`IPM_IDLE_BIT]) begin
        nxt_idle_req = 1'b1;
      end
    end
    if (I_SFR_RD && I_SFR_ADDR == `IPM_PWR_CTRL_ADDR) begin
      nxt_rdata = {flags_ff, 2'b00};
    end else if (I_SFR_RD) begin
      nxt_rdata = 8'h00;
    end
    unique case (mode_ff)
      ipm_pkg::IPM_RUN: begin
        // Entry waits for the writing instruction to retire
        if (stop_req_ff && I_INSTR_DONE) begin
          nxt_mode = ipm_pkg::IPM_STOP;
          nxt_stop_req = 1'b0;
          nxt_reg_off = I_REG_OFF_IN_STOP;
        end else if (idle_req_ff && I_INSTR_DONE) begin
          nxt_mode = ipm_pkg::IPM_IDLE;
        end
      end
      ipm_pkg::IPM_IDLE: begin
        if (pin_sync || I_WDT_EXPIRED) begin
          nxt_mode = ipm_pkg::IPM_RUN;
          nxt_idle_req = 1'b0;
          nxt_rst_req = 1'b1;
        end else if (I_IRQ_PENDING) begin
          nxt_mode = ipm_pkg::IPM_RUN;
          nxt_idle_req = 1'b0;
          nxt_wake = 1'b1;
        end
      end
      ipm_pkg::IPM_STOP: begin
        // With the regulator down only the pin can revive the part
        if (pin_sync || (!reg_off_ff && I_MCD_ENABLE && mcd_sync)) begin
          nxt_mode = ipm_pkg::IPM_RUN;
          nxt_reg_off = 1'b0;
          nxt_rst_req = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      mode_ff <= ipm_pkg::IPM_RUN;
      flags_ff <= 6'h00;
      idle_req_ff <= 1'b0;
      stop_req_ff <= 1'b0;
      reg_off_ff <= 1'b0;
      wake_ff <= 1'b0;
      rst_req_ff <= 1'b0;
      rdata_ff <= `IPM_PWR_CTRL_RST;
    end else begin
      mode_ff <= nxt_mode;
      flags_ff <= nxt_flags;
      idle_req_ff <= nxt_idle_req;
      stop_req_ff <= nxt_stop_req;
      reg_off_ff <= nxt_reg_off;
      wake_ff <= nxt_wake;
      rst_req_ff <= nxt_rst_req;
      rdata_ff <= nxt_rdata;
    end
  end

  // Idle gates only the core clock; registers hold since nothing else is gated
  assign O_CORE_CLK_EN = (mode_ff == ipm_pkg::IPM_RUN);
  assign O_PERIPH_CLK_EN = (mode_ff != ipm_pkg::IPM_STOP);
  assign O_OSC_EN = (mode_ff != ipm_pkg::IPM_STOP);
  assign O_REGULATOR_EN = !(mode_ff == ipm_pkg::IPM_STOP && reg_off_ff);
  assign O_IRQ_WAKE = wake_ff;
  assign O_SYS_RESET_REQ = rst_req_ff;
  assign O_RESET_VECTOR = `IPM_RESET_VECTOR;
  assign O_IDLE = (mode_ff == ipm_pkg::IPM_IDLE);
  assign O_STOP = (mode_ff == ipm_pkg::IPM_STOP);
  assign O_SFR_RDATA = rdata_ff;
endmodule // ipm_power_ctrl

// ### ipm_power_ctrl_assertions.sv
// Purpose: power-mode checker
// Assumes: bound to ipm_power_ctrl
// Notes: pin and detector-timeout wake inputs pass a 2-flop sync; interrupt and watchdog do not
`timescale 1ns/1ps
module ipm_power_ctrl_assertions (
  input wire logic I_REF_CLK, I_RESET_N, I_SFR_WR, I_INSTR_DONE, // Clock, reset, bus
  input wire logic [7:0] I_SFR_ADDR, I_SFR_WDATA, // Register write
  input wire logic I_IRQ_PENDING, I_WDT_EXPIRED, I_MCD_TIMEOUT, I_PIN_RESET, // Wake causes
  input wire logic O_CORE_CLK_EN, O_PERIPH_CLK_EN, O_OSC_EN, O_REGULATOR_EN, // Enables
  input wire logic O_SYS_RESET_REQ, O_IDLE, O_STOP // Modes
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);
  sequence s_idle_wr;
    I_SFR_WR && I_SFR_ADDR == 8'h87 && I_SFR_WDATA[1:0] == 2'b01 ##1 I_INSTR_DONE;
  endsequence
  chk_idle_entry: assert property (s_idle_wr |-> ##[1:2] O_IDLE) else $error("no idle");
  chk_idle_clk: assert property (O_IDLE |-> !O_CORE_CLK_EN && O_PERIPH_CLK_EN && O_OSC_EN)
    else $error("idle clocks");
  chk_irq_wake: assert property (O_IDLE && I_IRQ_PENDING |=> !O_IDLE && O_CORE_CLK_EN)
    else $error("irq wake");
  chk_wdt_wake: assert property (O_IDLE && I_WDT_EXPIRED |=> O_SYS_RESET_REQ)
    else $error("wdt wake");
  chk_stop_clk: assert property (O_STOP |-> !(O_OSC_EN || O_PERIPH_CLK_EN || O_CORE_CLK_EN))
    else $error("stop clocks");
  chk_stop_hold: assert property (
    (O_STOP && !I_PIN_RESET && !(I_MCD_TIMEOUT && O_REGULATOR_EN))[*3] |=> O_STOP)
    else $error("stop left");
  chk_pin_wake: assert property (O_STOP && $rose(I_PIN_RESET) |-> ##[2:5] O_SYS_RESET_REQ)
    else $error("pin wake");
  chk_reg_on: assert property (!O_STOP |-> O_REGULATOR_EN) else $error("reg off");
endmodule // ipm_power_ctrl_assertions
bind ipm_power_ctrl ipm_power_ctrl_assertions u_ipm_power_ctrl_assertions (.*);

// ### ipm_sync2.sv
// Purpose: two-flop synchroniser for asynchronous wake/reset levels
// Assumes: level inputs from outside the clock domain
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module ipm_sync2 (
  input wire logic i_clk, // Clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_d, // Asynchronous level
  output logic o_q // Synchronised level
);
  logic s1_ff;
  logic s2_ff;
  logic nxt_s1;
  logic nxt_s2;
  always_comb begin
    nxt_s1 = i_d;
    nxt_s2 = s1_ff;
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
    end
  end
  assign o_q = s2_ff;
endmodule // ipm_sync2

// ### tb_ipm_power_ctrl.sv
// Purpose: bench for the power-mode controller
// Assumes: inputs change at the falling edge
// Notes: flags come from a seeded LFSR
`timescale 1ns/1ps
module tb_ipm_power_ctrl;
  logic I_REF_CLK, I_RESET_N, I_SFR_WR, I_SFR_RD, I_INSTR_DONE, I_IRQ_PENDING, I_WDT_EXPIRED;
  logic I_MCD_ENABLE, I_MCD_TIMEOUT, I_PIN_RESET, I_REG_OFF_IN_STOP, O_CORE_CLK_EN, O_OSC_EN;
  logic O_PERIPH_CLK_EN, O_REGULATOR_EN, O_IRQ_WAKE, O_SYS_RESET_REQ, O_IDLE, O_STOP;
  logic [7:0] I_SFR_ADDR, I_SFR_WDATA, O_SFR_RDATA, q;
  logic [15:0] O_RESET_VECTOR;
  logic [1:0] seen;
  logic [31:0] rnd = 32'h4E655CD8;
  int err_total, n_tests;
  ipm_power_ctrl u_ipm_power_ctrl (.*);
  ipm_core_model u_ipm_core_model (.i_clk(I_REF_CLK), .i_rdata(O_SFR_RDATA), .o_addr(I_SFR_ADDR),
    .o_wdata(I_SFR_WDATA), .o_wr(I_SFR_WR), .o_rd(I_SFR_RD), .o_done(I_INSTR_DONE));
  initial begin
    I_REF_CLK = 1'b0;
    forever #5 I_REF_CLK = ~I_REF_CLK;
  end
  // Pulses are one cycle wide, so they are caught here
  always @(posedge I_REF_CLK) seen <= seen | {O_SYS_RESET_REQ, O_IRQ_WAKE};
  function automatic logic [7:0] exp_rd(input logic [7:0] w);
    return {w[7:2], 2'b00};
  endfunction
  task automatic step(input int n);
    repeat (n) @(negedge I_REF_CLK);
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {I_RESET_N, I_IRQ_PENDING, I_WDT_EXPIRED, I_MCD_ENABLE, I_MCD_TIMEOUT, seen} = '0;
    {I_PIN_RESET, I_REG_OFF_IN_STOP} = 2'b00;
    step(12);
    I_RESET_N = 1'b1;
    u_ipm_core_model.rd_reg(q);
    chk8(q, 8'h00);
    // A write elsewhere must leave the flags alone; other addresses read zero
    u_ipm_core_model.wr_reg(8'hFC);
    u_ipm_core_model.wr_reg(8'h00, 8'h80);
    u_ipm_core_model.rd_reg(q);
    chk8(q, 8'hFC);
    u_ipm_core_model.rd_reg(q, 8'h80);
    chk8(q, 8'h00);
    repeat (3) begin
      rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
      u_ipm_core_model.wr_reg({rnd[7:2], 2'b01});
      step(1);
      chk1(O_IDLE & O_PERIPH_CLK_EN & O_OSC_EN & ~O_CORE_CLK_EN, 1'b1);
      I_IRQ_PENDING = 1'b1;
      step(1);
      I_IRQ_PENDING = 1'b0;
      step(1);
      chk1(O_IDLE | ~seen[0], 1'b0);
      u_ipm_core_model.rd_reg(q);
      chk8(q, exp_rd(rnd[7:0]));
      u_ipm_core_model.wr_reg(8'h01);
      step(1);
      I_WDT_EXPIRED = 1'b1;
      step(1);
      I_WDT_EXPIRED = 1'b0;
      step(1);
      chk1(O_IDLE | ~seen[1] | (|O_RESET_VECTOR), 1'b0);
      seen = 2'b00;
    end
    for (int k = 0; k < 2; k++) begin
      {I_REG_OFF_IN_STOP, I_MCD_ENABLE} = {k[0], 1'b1};
      u_ipm_core_model.wr_reg(8'h03);
      step(1);
      chk1(O_STOP & ~(O_OSC_EN | O_PERIPH_CLK_EN | O_CORE_CLK_EN), 1'b1);
      chk1(O_REGULATOR_EN, ~k[0]);
      {I_IRQ_PENDING, I_WDT_EXPIRED, I_MCD_TIMEOUT} = 3'b111;
      step(1);
      I_WDT_EXPIRED = 1'b0;
      step(4);
      chk1(O_STOP, k[0]);
      {I_IRQ_PENDING, I_MCD_TIMEOUT, I_PIN_RESET} = {2'b00, k[0]};
      step(4);
      chk1(O_STOP | ~seen[1], 1'b0);
      {I_PIN_RESET, seen} = 3'b000;
      step(3);
    end
    end_of_test();
  end
  // About 100 cycles are needed; some sixty times that cuts a hang
  initial begin
    #60000;
    err_total++;
    end_of_test();
  end
endmodule // tb_ipm_power_ctrl
